// ==== design/mifm_pkg.sv ====
// Constants and carrier types for the modem interface fault monitor.
// Assumes a 25 MHz reference clock shared by all monitor logic.
`default_nettype none
package mifm_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int ACT_WIN_NS = 2560;
    localparam int ACT_WIN_CYC = ACT_WIN_NS / CLK_PERIOD_NS;
    localparam int TX_INT_NS = 320;
    localparam int TX_INT_CYC = TX_INT_NS / CLK_PERIOD_NS;
    localparam int ACT_W = 8;
    localparam int DIV_W = 4;
    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int RUN_W = 16;
    localparam int TS_W = 32;
    localparam int FILL_W = 9;
    localparam int BUF_CAP = 256;
    localparam int FILL_LO_PCT = 10;
    localparam int FILL_HI_PCT = 90;
    localparam int PCT_FULL = 100;
    localparam int LOG_DEPTH = 10;
    localparam int UF_DEPTH = 10;
    localparam int IDX_W = 4;
    localparam int CODE_W = 4;
    localparam int NFAULT = 9;
    localparam int SYNC_N = 5;
    // Synchroniser lanes
    localparam int LN_TXD = 0;
    localparam int LN_TXC = 1;
    localparam int LN_RXD = 2;
    localparam int LN_RXB = 3;
    localparam int LN_RXS = 4;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Bit 0 is the buffer underflow, code 0 in the log
    typedef struct packed {
        logic fill;
        logic prbs;
        logic demux;
        logic rxclk;
        logic rxd;
        logic txclk;
        logic txd;
        logic ovf;
        logic udf;
    } mifm_fault_type;
    typedef struct packed {
        logic [TS_W-1:0] stamp;
        logic onset;
        logic [CODE_W-1:0] code;
    } mifm_log_type;
endpackage
`default_nettype wire

// ==== design/mifm_top.sv ====
// Fault monitor for the terrestrial data interface of a satellite modem.
// Assumes pins and link clocks arrive unsynchronised; buffer, demux,
// decoder and time-of-day inputs come from logic on ref_clk_i.
//
// Function
// - AIS mode: flag transmit all-ones run
// - Stable mode: flag transmit constant data
// - Transmit data fault only monitors, data passes
// - Transmit clock dead: alarm, use internal clock
// - Underflow alarm as momentary event
// - Overflow alarm on buffer overflow
// - Underflow logged in stored-fault memory
// - First ten underflow timestamps kept
// - AIS mode: flag receive all-ones run
// - Stable mode: flag receive constant data
// - Receive data passes; relay shows fault
// - Buffer clock dead: alarm, use satellite clock
// - Frame_alignment_loss_fault fault on lost alignment
// - Demux fault: insert all ones, request switch
// - Demux fault sent as backward alarm
// - Alarm when 2047 pattern not received
// - Fill alarm below 10% or above 90%
// - Log ten occurrences, onset and clear
// - Alarms never request redundancy switch
`default_nettype none

// ------------------------------------------------------------
// Run detector for all-ones and data-stable faults
// ------------------------------------------------------------
module mifm_run_det
    import mifm_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic strobe_i,
    input wire logic bit_i,
    input wire logic ones_only_i,
    input wire logic [RUN_W-1:0] run_len_i,
    output logic fault_o
);
    logic prev;
    logic [RUN_W-1:0] run;
    logic [RUN_W-1:0] next_run;

    assign next_run = (run == {RUN_W{1'b1}}) ? run : run + 1'b1;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            prev <= 1'b0;
            run <= '0;
            fault_o <= 1'b0;
        end else if (strobe_i) begin
            prev <= bit_i;
            if (bit_i != prev) begin
                run <= {{(RUN_W-1){1'b0}}, 1'b1};
                fault_o <= 1'b0;
            end else begin
                run <= next_run;
                // Ones-only ignores zero runs; stable mode takes either
                if (next_run >= run_len_i && (!ones_only_i || bit_i)) begin
                    fault_o <= 1'b1;
                end
            end
        end
    end
endmodule

// ------------------------------------------------------------
// Clock activity detector
// ------------------------------------------------------------
module mifm_act_det
    import mifm_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic edge_i,
    output logic alarm_o
);
    logic [ACT_W-1:0] cnt;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt <= '0;
            alarm_o <= 1'b0;
        end else if (edge_i) begin
            cnt <= '0;
            alarm_o <= 1'b0;
        end else if (cnt == ACT_W'(ACT_WIN_CYC - 1)) begin
            alarm_o <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule

// ------------------------------------------------------------
// Top
// ------------------------------------------------------------
module mifm_top
    import mifm_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic tx_data_i,
    input wire logic tx_clk_i,
    input wire logic rx_data_i,
    input wire logic rx_buf_clk_i,
    input wire logic rx_sat_clk_i,
    input wire logic tx_ones_mode_i,
    input wire logic rx_ones_mode_i,
    input wire logic [RUN_W-1:0] run_len_i,
    input wire logic buf_underflow_i,
    input wire logic buf_overflow_i,
    input wire logic [FILL_W-1:0] buf_fill_i,
    input wire logic frame_aligned_i,
    input wire logic carrier_i,
    input wire logic prbs_lock_i,
    input wire logic [TS_W-1:0] time_i,
    input wire logic log_clear_i,
    input wire logic [IDX_W-1:0] log_rd_idx_i,
    input wire logic [IDX_W-1:0] uf_rd_idx_i,
    output logic tx_data_o,
    output logic rx_data_o,
    output var mifm_fault_type fault_o,
    output logic tx_timing_internal_o,
    output logic rx_clk_from_sat_o,
    output logic rx_relay_o,
    output logic switchover_req_o,
    output logic backward_alarm_o,
    output logic [IDX_W-1:0] log_count_o,
    output var mifm_log_type log_rd_o,
    output logic [IDX_W-1:0] uf_count_o,
    output logic [TS_W-1:0] uf_rd_o
);
    function automatic logic [IDX_W-1:0] first_set(input logic [NFAULT-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = NFAULT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction

    // True when fill is below pct percent of capacity
    function automatic logic fill_below(input logic [FILL_W-1:0] fill, input int pct);
        return int'(fill) * PCT_FULL < BUF_CAP * pct;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and edge finding
    // ------------------------------------------------------------
    logic [SYNC_N-1:0] sync1;
    logic [SYNC_N-1:0] sync2;
    logic [SYNC_N-1:0] sync3;
    logic tx_ext_edge;
    logic rx_buf_edge;
    logic rx_sat_edge;
    logic tx_int_tick;
    logic tx_edge;
    logic rx_edge;
    logic [DIV_W-1:0] tx_div;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= {rx_sat_clk_i, rx_buf_clk_i, rx_data_i, tx_clk_i, tx_data_i};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign tx_ext_edge = sync2[LN_TXC] & ~sync3[LN_TXC];
    assign rx_buf_edge = sync2[LN_RXB] & ~sync3[LN_RXB];
    assign rx_sat_edge = sync2[LN_RXS] & ~sync3[LN_RXS];

    // Internal transmit timing runs free so fallback never stalls
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tx_div <= '0;
        end else if (tx_div == DIV_W'(TX_INT_CYC - 1)) begin
            tx_div <= '0;
        end else begin
            tx_div <= tx_div + 1'b1;
        end
    end

    assign tx_int_tick = (tx_div == '0);
    assign tx_edge = fault_o.txclk ? tx_int_tick : tx_ext_edge;
    assign rx_edge = fault_o.rxclk ? rx_sat_edge : rx_buf_edge;

    // ------------------------------------------------------------
    // Detectors
    // ------------------------------------------------------------
    logic txd_fault;
    logic rxd_fault;
    logic txclk_alarm;
    logic rxclk_alarm;
    logic frame_lost;
    logic fill_bad;

    mifm_run_det u_tx_run (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .strobe_i(tx_edge),
        .bit_i(sync2[LN_TXD]),
        .ones_only_i(tx_ones_mode_i),
        .run_len_i(run_len_i),
        .fault_o(txd_fault)
    );

    mifm_run_det u_rx_run (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .strobe_i(rx_edge),
        .bit_i(sync2[LN_RXD]),
        .ones_only_i(rx_ones_mode_i),
        .run_len_i(run_len_i),
        .fault_o(rxd_fault)
    );

    mifm_act_det u_tx_act (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .edge_i(tx_ext_edge),
        .alarm_o(txclk_alarm)
    );

    mifm_act_det u_rx_act (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .edge_i(rx_buf_edge),
        .alarm_o(rxclk_alarm)
    );

    assign frame_lost = ~frame_aligned_i | ~carrier_i;
    assign fill_bad = fill_below(buf_fill_i, FILL_LO_PCT) | (int'(buf_fill_i) * PCT_FULL > BUF_CAP * FILL_HI_PCT);

    // ------------------------------------------------------------
    // Fault flags and actions
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fault_o <= '0;
        end else begin
            fault_o.udf <= buf_underflow_i;
            fault_o.ovf <= buf_overflow_i;
            fault_o.txd <= txd_fault;
            fault_o.txclk <= txclk_alarm;
            fault_o.rxd <= rxd_fault;
            fault_o.rxclk <= rxclk_alarm;
            fault_o.demux <= frame_lost;
            fault_o.prbs <= ~prbs_lock_i;
            fault_o.fill <= fill_bad;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tx_data_o <= 1'b0;
            rx_data_o <= 1'b1;
            tx_timing_internal_o <= 1'b0;
            rx_clk_from_sat_o <= 1'b0;
            rx_relay_o <= 1'b0;
            switchover_req_o <= 1'b0;
            backward_alarm_o <= 1'b0;
        end else begin
            tx_data_o <= sync2[LN_TXD];
            rx_data_o <= fault_o.demux | sync2[LN_RXD];
            tx_timing_internal_o <= fault_o.txclk;
            rx_clk_from_sat_o <= fault_o.rxclk;
            rx_relay_o <= fault_o.rxd;
            // Only the major demux fault may force a switch
            switchover_req_o <= fault_o.demux;
            backward_alarm_o <= fault_o.demux;
        end
    end

    // ------------------------------------------------------------
    // Stored-fault memory
    // ------------------------------------------------------------
    // Full memory still tracks the snapshot so a later clear
    // leaves no stale pending changes behind
    mifm_log_type log_mem [LOG_DEPTH];
    logic [NFAULT-1:0] snap;
    logic [NFAULT-1:0] diff;
    logic [IDX_W-1:0] chg_idx;

    assign diff = fault_o ^ snap;
    assign chg_idx = first_set(diff);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            snap <= '0;
            log_count_o <= '0;
        end else begin
            if (diff != '0) begin
                snap[chg_idx] <= fault_o[chg_idx];
            end
            if (log_clear_i) begin
                log_count_o <= '0;
            end else if (diff != '0 && log_count_o < IDX_W'(LOG_DEPTH)) begin
                log_mem[log_count_o] <= '{stamp: time_i, onset: fault_o[chg_idx], code: chg_idx};
                log_count_o <= log_count_o + 1'b1;
            end
        end
    end

    // Underflow times survive a log clear
    logic [TS_W-1:0] uf_mem [UF_DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            uf_count_o <= '0;
        end else if (buf_underflow_i && uf_count_o < IDX_W'(UF_DEPTH)) begin
            uf_mem[uf_count_o] <= time_i;
            uf_count_o <= uf_count_o + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            log_rd_o <= '0;
            uf_rd_o <= '0;
        end else begin
            log_rd_o <= (log_rd_idx_i < log_count_o) ? log_mem[log_rd_idx_i] : '0;
            uf_rd_o <= (uf_rd_idx_i < uf_count_o) ? uf_mem[uf_rd_idx_i] : '0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    a_tx_data_pass: assert property (tx_data_o == $past(sync2[LN_TXD]))
        else $error("transmit data not passed through");
    a_txclk_fallback: assert property (txclk_alarm |=> ##1 tx_timing_internal_o)
        else $error("no internal timing on dead tx clock");
    a_act_window: assert property (rx_buf_edge ##1 !rx_buf_edge [*8] |-> !rxclk_alarm)
        else $error("activity alarm before window ends");
    a_udf_alarm: assert property (buf_underflow_i |=> fault_o.udf)
        else $error("underflow not raised");
    a_ovf_alarm: assert property (buf_overflow_i |=> fault_o.ovf)
        else $error("overflow not raised");
    a_uf_keep_first: assert property (uf_count_o == 4'ha |=> $stable(uf_mem[0]) && uf_count_o == 4'ha)
        else $error("underflow times overwritten");
    a_ais_insert: assert property (frame_lost |=> ##1 rx_data_o && switchover_req_o && backward_alarm_o)
        else $error("demux fault actions missing");
    a_alarm_noswitch: assert property (switchover_req_o |-> $past(fault_o.demux))
        else $error("switch requested without demux fault");
    a_prbs_alarm: assert property (!prbs_lock_i |=> fault_o.prbs)
        else $error("pattern lock alarm missing");
    a_log_bound: assert property (log_count_o <= 4'ha)
        else $error("fault log past ten entries");
    a_log_onset: assert property ($rose(fault_o.udf) && log_count_o < 4'ha && !log_clear_i
        |=> log_count_o == $past(log_count_o) + 4'h1)
        else $error("underflow onset not logged");

    c_txclk_lost: cover property ($rose(tx_timing_internal_o));
    c_uf_full: cover property ($rose(uf_count_o == 4'ha));
    c_demux: cover property ($rose(switchover_req_o));
    c_tx_fault: cover property ($rose(fault_o.txd));
endmodule
`default_nettype wire

// ==== tb/mifm_far_end.sv ====
// Far-end model: customer transmit equipment and satellite receive path.
// Assumes the bench sets run enables and data modes; clocks are 320 ns.
`default_nettype none
module mifm_far_end (
    input wire logic tx_run_i,
    input wire logic rx_run_i,
    input wire logic [1:0] tx_mode_i,
    input wire logic [1:0] rx_mode_i,
    output logic tx_clk_o,
    output logic tx_data_o,
    output logic rx_buf_clk_o,
    output logic rx_sat_clk_o,
    output logic rx_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Mode 1 all ones, 2 all zeros, else alternating bits
    function automatic logic next_bit(input logic [1:0] m, input logic last);
        case (m)
            2'd1: return 1'b1;
            2'd2: return 1'b0;
            default: return !last;
        endcase
    endfunction
    // A stopped clock stands low; data keeps its own schedule
    initial begin
        tx_clk_o = 1'b0;
        tx_data_o = 1'b0;
        #13;
        forever begin
            tx_data_o = next_bit(tx_mode_i, tx_data_o);
            #160;
            tx_clk_o = tx_run_i;
            #160;
            tx_clk_o = 1'b0;
        end
    end
    // Satellite clock runs free so the buffer clock can be lost alone
    initial begin
        rx_buf_clk_o = 1'b0;
        rx_sat_clk_o = 1'b0;
        rx_data_o = 1'b0;
        #29;
        forever begin
            rx_data_o = next_bit(rx_mode_i, rx_data_o);
            #80;
            rx_sat_clk_o = 1'b1;
            #80;
            rx_buf_clk_o = rx_run_i;
            #80;
            rx_sat_clk_o = 1'b0;
            #80;
            rx_buf_clk_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the interface fault monitor.
// Assumes mifm_far_end drives the pins; notes are checked at falling edges.
`default_nettype none
module tb_top import mifm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int sel; logic [63:0] exp; logic [63:0] mask;} mifm_note_type;
    logic ref_clk_i, srst_i, tx_ones_mode_i, rx_ones_mode_i, buf_underflow_i, buf_overflow_i;
    logic frame_aligned_i, carrier_i, prbs_lock_i, log_clear_i, tx_run, rx_run;
    logic tx_data_i, tx_clk_i, rx_data_i, rx_buf_clk_i, rx_sat_clk_i;
    logic [RUN_W-1:0] run_len_i;
    logic [FILL_W-1:0] buf_fill_i;
    logic [TS_W-1:0] time_i, uf_rd_o;
    logic [IDX_W-1:0] log_rd_idx_i, uf_rd_idx_i, log_count_o, uf_count_o;
    logic [1:0] tx_mode, rx_mode;
    logic tx_data_o, rx_data_o, tx_timing_internal_o, rx_clk_from_sat_o;
    logic rx_relay_o, switchover_req_o, backward_alarm_o;
    mifm_fault_type fault_o;
    mifm_log_type log_rd_o;
    int errors, compares, cycles;
    mifm_note_type notes[$];
    logic [TS_W-1:0] stamps[12];
    int fills[7] = '{0, 25, 26, 128, 230, 231, 256};
    logic [1:0] dmode[5] = '{1, 2, 2, 1, 0};
    logic omode[5] = '{1, 1, 0, 0, 0};
    logic dexp[5] = '{1, 0, 1, 1, 0};
    string names[9] = '{"fault", "alarm_out", "log_count", "log_entry", "uf_count", "uf_time",
        "clk_fallback", "rx_out", "tx_out"};

    mifm_top dut_u (.ref_clk_i, .srst_i, .tx_data_i, .tx_clk_i, .rx_data_i, .rx_buf_clk_i,
        .rx_sat_clk_i, .tx_ones_mode_i, .rx_ones_mode_i, .run_len_i, .buf_underflow_i,
        .buf_overflow_i, .buf_fill_i, .frame_aligned_i, .carrier_i, .prbs_lock_i, .time_i,
        .log_clear_i, .log_rd_idx_i, .uf_rd_idx_i, .tx_data_o, .rx_data_o, .fault_o,
        .tx_timing_internal_o, .rx_clk_from_sat_o, .rx_relay_o, .switchover_req_o,
        .backward_alarm_o, .log_count_o, .log_rd_o, .uf_count_o, .uf_rd_o);
    mifm_far_end far_u (.tx_run_i(tx_run), .rx_run_i(rx_run), .tx_mode_i(tx_mode),
        .rx_mode_i(rx_mode), .tx_clk_o(tx_clk_i), .tx_data_o(tx_data_i),
        .rx_buf_clk_o(rx_buf_clk_i), .rx_sat_clk_o(rx_sat_clk_i), .rx_data_o(rx_data_i));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    function automatic logic [63:0] obs(input int sel);
        case (sel)
            0: return 64'(fault_o);
            1: return {61'h0, switchover_req_o, backward_alarm_o, rx_data_o};
            2: return 64'(log_count_o);
            3: return 64'(log_rd_o);
            4: return 64'(uf_count_o);
            5: return 64'(uf_rd_o);
            6: return {62'h0, tx_timing_internal_o, rx_clk_from_sat_o};
            7: return {62'h0, rx_relay_o, rx_data_o};
            default: return {63'h0, tx_data_o};
        endcase
    endfunction
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic note(input int sel, input logic [63:0] exp, input logic [63:0] mask);
        notes.push_back('{sel, exp, mask});
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Outputs are settled at the falling edge, so notes are judged there
    always @(negedge ref_clk_i) begin
        mifm_note_type n;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            check(names[n.sel], obs(n.sel) & n.mask, n.exp & n.mask);
        end
    end
    // A hung run still reaches the verdict
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        int f;
        {tx_ones_mode_i, rx_ones_mode_i, frame_aligned_i, carrier_i, prbs_lock_i} = 5'h1f;
        {buf_underflow_i, buf_overflow_i, log_clear_i, tx_run, rx_run} = 5'h03;
        {tx_mode, rx_mode, log_rd_idx_i, uf_rd_idx_i, time_i} = '0;
        run_len_i = 16'h0004;
        buf_fill_i = 9'h080;
        srst_i = 1'b1;
        void'($urandom(32'hebec));
        ticks(10);
        note(0, 0, '1);
        note(1, 1, '1);
        note(2, 0, '1);
        srst_i <= 1'b0;
        ticks(3);
        for (int i = 0; i < 12; i++) begin
            stamps[i] = $urandom;
            buf_underflow_i <= 1'b1;
            time_i <= stamps[i];
            ticks(1);
            if (i == 4) note(0, 1, 1);
        end
        buf_underflow_i <= 1'b0;
        ticks(3);
        note(0, 0, 1);
        for (int i = 0; i <= UF_DEPTH; i++) begin
            uf_rd_idx_i <= IDX_W'(i);
            ticks(2);
            note(5, i < UF_DEPTH ? 64'(stamps[i]) : 64'h0, '1);
        end
        note(4, UF_DEPTH, '1);
        note(2, 2, '1);
        log_rd_idx_i <= 4'h0;
        ticks(2);
        note(3, 'h10, 'h1f);
        log_rd_idx_i <= 4'h1;
        ticks(2);
        note(3, 'h00, 'h1f);
        log_clear_i <= 1'b1;
        ticks(1);
        log_clear_i <= 1'b0;
        ticks(2);
        note(2, 0, '1);
        buf_overflow_i <= 1'b1;
        ticks(2);
        note(0, 'h2, 'h2);
        note(1, 0, 'h4);
        buf_overflow_i <= 1'b0;
        prbs_lock_i <= 1'b0;
        ticks(2);
        note(0, 'h80, 'h82);
        note(1, 0, 'h4);
        prbs_lock_i <= 1'b1;
        // Fill boundaries first, then one random mid-range level
        for (int i = 0; i < 8; i++) begin
            f = (i < 7) ? fills[i] : 26 + int'($urandom_range(204));
            buf_fill_i <= FILL_W'(f);
            ticks(2);
            note(0, {f * 100 < FILL_LO_PCT * BUF_CAP || f * 100 > FILL_HI_PCT * BUF_CAP, 8'h0}, 'h180);
            note(1, 0, 'h4);
        end
        buf_fill_i <= 9'h080;
        rx_mode <= 2'd2;
        ticks(24);
        for (int c = 0; c < 2; c++) begin
            frame_aligned_i <= (c != 0);
            carrier_i <= (c == 0);
            ticks(3);
            note(0, 'h40, 'h40);
            note(1, 'h7, 'h7);
            frame_aligned_i <= 1'b1;
            carrier_i <= 1'b1;
            ticks(3);
            note(1, 0, 'h7);
        end
        // Ones-only and data-stable detection on both directions
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 5; k++) begin
                if (p == 0) tx_mode <= dmode[k];
                else rx_mode <= dmode[k];
                if (p == 0) tx_ones_mode_i <= omode[k];
                else rx_ones_mode_i <= omode[k];
                ticks(80);
                note(0, 64'(dexp[k]) << (p ? 4 : 2), p ? 'h10 : 'h4);
                if (p == 0 && k < 4) note(8, 64'(dmode[k] == 2'd1), 1);
                if (p == 1) note(7, {dexp[k], dmode[k] == 2'd1}, k < 4 ? 3 : 2);
            end
        end
        for (int p = 0; p < 2; p++) begin
            tx_run <= (p != 0);
            rx_run <= (p == 0);
            ticks(80);
            note(0, p ? 'h20 : 'h8, 'h28);
            note(6, p ? 1 : 2, 3);
            tx_run <= 1'b1;
            rx_run <= 1'b1;
            ticks(24);
            note(0, 0, 'h28);
            note(6, 0, 3);
        end
        note(2, LOG_DEPTH, '1);
        ticks(2);
        wrap_up();
    end
endmodule
`default_nettype wire
